/* File: logic/smr_defs.svh */
// Purpose: constants for the management interrupt and soft reset ends
// Assumes: one shared 40 MHz clock, counts are in clocks of that clock
// Notes:   definitions only
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH
// ==========================================================
// addresses
`define SMR_RESET_VEC    32'h0FFFFFF0
`define SMR_BASE_RST     32'h00030000
`define SMR_HANDLER_OFS  32'h00008000
`define SMR_SAVE_TOP_OFS 32'h0000FFFF
`define SMR_RAM_SPAN     32'h00010000
// ==========================================================
// sequencer timing, in clocks
`define SMR_DRAIN_MIN    9'h002
`define SMR_ACT_TO_ADS   9'h014
`define SMR_SAVE_CLKS    9'h08B
`define SMR_RSTR_CLKS    9'h0EC
`define SMR_EXIT_CLKS    9'h002
`define SMR_POST_CLKS    9'h014
// ==========================================================
// system-end request timing, in clocks
`define SMR_INT_REARM    4'h4
`define SMR_TRAP_LEAD    4'h3
`endif

/* File: logic/smr_pkg.sv */
// Purpose: shared types for the management interrupt ends
// Assumes: included constants live in smr_defs.svh
// Notes:   types only
package smr_pkg;
   // ==========================================================
   // device-end sequencer
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DRAIN = 3'b001,
      ST_ACTW  = 3'b010,
      ST_SAVE  = 3'b011,
      ST_HNDL  = 3'b100,
      ST_RSTR  = 3'b101,
      ST_EXIT  = 3'b110,
      ST_POST  = 3'b111
   } smr_state_type;
   // class of an interrupted instruction offered for restart
   typedef enum logic [1:0] {
      OP_IO    = 2'b00,
      OP_HALT  = 2'b01,
      OP_OTHER = 2'b10
   } smr_opclass_type;
endpackage

/* File: logic/smr_link_if.sv */
// Purpose: pins between processor end and system logic end
// Assumes: both ends on the same clock
// Notes:   all pins driven at all times, none tri-state
`timescale 1ns/1ps
interface smr_link_if (
   input wire logic clk_sys_i
);
   logic sysmgmt_int_n;    // falling edge requests management mode
   logic soft_reset_in;    // high requests a soft reset
   logic flush_n;          // low flushes the processor cache
   logic sysmgmt_active_n; // low while in management mode
   logic addr_strobe_n;    // low for the first bus cycle after a phase
   modport cpu (
      input  sysmgmt_int_n,
      input  soft_reset_in,
      input  flush_n,
      output sysmgmt_active_n,
      output addr_strobe_n
   );
   modport sys (
      output sysmgmt_int_n,
      output soft_reset_in,
      output flush_n,
      input  sysmgmt_active_n,
      input  addr_strobe_n
   );
endinterface

/* File: logic/smr_cpu_end.sv */
// Purpose: processor-side management interrupt and soft reset sequencer
// Assumes: core supplies boundary, lock and write buffer status
// Notes:   bus engine and save map are outside; phases are timed here
`timescale 1ns/1ps
`include "smr_defs.svh"
module smr_cpu_end (
   input  wire logic                 clk_sys_i,
   input  wire logic                 srst_i,
   smr_link_if.cpu                   link,
   input  wire logic                 boundary_i,
   input  wire logic                 locked_i,
   input  wire logic                 nmi_req_i,
   input  wire logic                 wbuf_empty_i,
   input  wire logic                 resume_instr_i,
   input  wire logic                 restart_req_i,
   input  wire smr_pkg::smr_opclass_type restart_class_i,
   input  wire logic                 base_wr_i,
   input  wire logic [31:0]          base_wdata_i,
   input  wire logic                 cr0_wr_i,
   input  wire logic                 cd_i,
   input  wire logic                 nw_i,
   output logic                      smi_taken_o,
   output logic                      nmi_taken_o,
   output logic                      in_smm_o,
   output logic                      fetch_go_o,
   output logic [31:0]               fetch_addr_o,
   output logic [31:0]               save_top_o,
   output logic [31:0]               base_o,
   output logic                      cd_o,
   output logic                      nw_o,
   output logic                      snoop_en_o,
   output logic                      restart_ok_o,
   output logic                      resume_done_o,
   output logic                      core_reset_o,
   output logic                      flush_o
);
   // ==========================================================
   // synchronisers
   logic [2:0] smi_s_r, smi_s_nxt, srs_s_r, srs_s_nxt, fl_s_r, fl_s_nxt;
   logic       smi_lvl_r, smi_lvl_nxt, srs_lvl_r, srs_lvl_nxt, fl_lvl_r, fl_lvl_nxt;
   logic       smi_fall, srs_rise;

   // a one-clock pulse must still count, and no two adjacent stages ever
   // hold it together, so stage three is taken as the level by itself
   function automatic logic agreed(input logic [2:0] s);
      agreed = s[2];
   endfunction

   always_comb begin
      smi_s_nxt   = {smi_s_r[1:0], link.sysmgmt_int_n};
      srs_s_nxt   = {srs_s_r[1:0], link.soft_reset_in};
      fl_s_nxt    = {fl_s_r[1:0], link.flush_n};
      smi_lvl_nxt = agreed(smi_s_r);
      srs_lvl_nxt = agreed(srs_s_r);
      fl_lvl_nxt  = agreed(fl_s_r);
      smi_fall    = smi_lvl_r & ~smi_lvl_nxt;
      srs_rise    = ~srs_lvl_r & srs_lvl_nxt;
   end

   // synchroniser flops; hard reset leaves lines idle
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         smi_s_r   <= 3'h7;
         srs_s_r   <= 3'h0;
         fl_s_r    <= 3'h7;
         smi_lvl_r <= 1'b1;
         srs_lvl_r <= 1'b0;
         fl_lvl_r  <= 1'b1;
      end else begin
         smi_s_r   <= smi_s_nxt;
         srs_s_r   <= srs_s_nxt;
         fl_s_r    <= fl_s_nxt;
         smi_lvl_r <= smi_lvl_nxt;
         srs_lvl_r <= srs_lvl_nxt;
         fl_lvl_r  <= fl_lvl_nxt;
      end
   end

   // ==========================================================
   // state kept across soft reset
   logic [31:0] base_r, base_nxt;
   logic        cd_r, cd_nxt, nw_r, nw_nxt;

   // only hard reset touches these; soft reset passes them by
   always_comb begin
      base_nxt = base_wr_i ? base_wdata_i : base_r;
      cd_nxt   = cr0_wr_i ? cd_i : cd_r;
      nw_nxt   = cr0_wr_i ? nw_i : nw_r;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         base_r <= `SMR_BASE_RST;
         cd_r   <= 1'b1;
         nw_r   <= 1'b1;
      end else begin
         base_r <= base_nxt;
         cd_r   <= cd_nxt;
         nw_r   <= nw_nxt;
      end
   end

   // ==========================================================
   // entry and exit sequencer
   smr_pkg::smr_state_type st_r, st_nxt;
   logic [8:0]  cnt_r, cnt_nxt;
   logic        pend_r, pend_nxt, act_n_r, act_n_nxt, ads_n_r, ads_n_nxt;
   logic        go_r, go_nxt, done_r, done_nxt, crst_r, crst_nxt;
   logic [31:0] faddr_r, faddr_nxt;
   logic        take;

   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r + 9'h001;
      pend_nxt  = pend_r | smi_fall; // one pending request at most
      act_n_nxt = act_n_r;
      ads_n_nxt = 1'b1;
      go_nxt    = 1'b0;
      done_nxt  = 1'b0;
      crst_nxt  = 1'b0;
      faddr_nxt = faddr_r;
      // flags register interrupt enable plays no part here
      take      = (st_r == smr_pkg::ST_IDLE) & boundary_i & ~locked_i & pend_r;
      unique case (st_r)
         smr_pkg::ST_IDLE: begin
            cnt_nxt = 9'h000;
            if (take) begin
               pend_nxt = smi_fall;
               st_nxt   = smr_pkg::ST_DRAIN;
            end
         end
         smr_pkg::ST_DRAIN: begin
            // writes drain before the active output goes low
            if (wbuf_empty_i && cnt_r >= `SMR_DRAIN_MIN - 9'h001) begin
               act_n_nxt = 1'b0;
               cnt_nxt   = 9'h000;
               st_nxt    = smr_pkg::ST_ACTW;
            end
         end
         smr_pkg::ST_ACTW: begin
            if (cnt_r == `SMR_ACT_TO_ADS - 9'h001) begin
               ads_n_nxt = 1'b0;
               cnt_nxt   = 9'h000;
               st_nxt    = smr_pkg::ST_SAVE;
            end
         end
         smr_pkg::ST_SAVE: begin
            if (cnt_r == `SMR_SAVE_CLKS - 9'h001) begin
               go_nxt    = 1'b1;
               faddr_nxt = base_r + `SMR_HANDLER_OFS;
               st_nxt    = smr_pkg::ST_HNDL;
            end
         end
         smr_pkg::ST_HNDL: begin
            cnt_nxt = 9'h000;
            if (resume_instr_i)
               st_nxt = smr_pkg::ST_RSTR;
         end
         smr_pkg::ST_RSTR: begin
            // active stays low through the last restore read
            if (cnt_r == `SMR_RSTR_CLKS - 9'h001) begin
               cnt_nxt = 9'h000;
               st_nxt  = smr_pkg::ST_EXIT;
            end
         end
         smr_pkg::ST_EXIT: begin
            if (cnt_r == `SMR_EXIT_CLKS - 9'h001) begin
               act_n_nxt = 1'b1;
               cnt_nxt   = 9'h000;
               st_nxt    = smr_pkg::ST_POST;
            end
         end
         smr_pkg::ST_POST: begin
            if (cnt_r == `SMR_POST_CLKS - 9'h001) begin
               ads_n_nxt = 1'b0;
               done_nxt  = 1'b1;
               st_nxt    = smr_pkg::ST_IDLE;
            end
         end
      endcase
      // soft reset: state to idle, pending and active cleared, fetch from vector
      if (srs_rise) begin
         st_nxt    = smr_pkg::ST_IDLE;
         pend_nxt  = 1'b0;
         act_n_nxt = 1'b1;
         go_nxt    = 1'b1;
         crst_nxt  = 1'b1;
         faddr_nxt = `SMR_RESET_VEC;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         st_r    <= smr_pkg::ST_IDLE;
         cnt_r   <= 9'h000;
         pend_r  <= 1'b0;
         act_n_r <= 1'b1;
         ads_n_r <= 1'b1;
         go_r    <= 1'b0;
         done_r  <= 1'b0;
         crst_r  <= 1'b0;
         faddr_r <= `SMR_RESET_VEC;
      end else begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         pend_r  <= pend_nxt;
         act_n_r <= act_n_nxt;
         ads_n_r <= ads_n_nxt;
         go_r    <= go_nxt;
         done_r  <= done_nxt;
         crst_r  <= crst_nxt;
         faddr_r <= faddr_nxt;
      end
   end

   // ==========================================================
   // outputs; the active pin is a plain flop, never floated on hold
   assign link.sysmgmt_active_n = act_n_r;
   assign link.addr_strobe_n    = ads_n_r;
   assign smi_taken_o   = take;
   // NMI waits behind a pending management request, also in handler
   assign nmi_taken_o   = boundary_i & ~locked_i & nmi_req_i & ~pend_r
                          & (st_r == smr_pkg::ST_IDLE);
   assign in_smm_o      = ~act_n_r;
   assign fetch_go_o    = go_r;
   assign fetch_addr_o  = faddr_r;
   assign save_top_o    = base_r + `SMR_SAVE_TOP_OFS;
   assign base_o        = base_r;
   assign cd_o          = cd_r;
   assign nw_o          = nw_r;
   assign snoop_en_o    = 1'b1;
   // other opcodes are refused rather than left undefined
   assign restart_ok_o  = restart_req_i & (restart_class_i != smr_pkg::OP_OTHER);
   assign resume_done_o = done_r;
   assign core_reset_o  = crst_r;
   assign flush_o       = ~fl_lvl_r;
endmodule

/* File: logic/smr_sys_end.sv */
// Purpose: system logic end: requests, soft reset, flush, memory decode
// Assumes: same clock as processor end; srst_i is power-up hard reset
// Notes:   request spacing is enforced here, not by the requester
`timescale 1ns/1ps
`include "smr_defs.svh"
module smr_sys_end (
   input  wire logic        clk_sys_i,
   input  wire logic        srst_i,
   smr_link_if.sys          link,
   input  wire logic        smi_req_i,
   input  wire logic        trap_req_i,
   input  wire logic        overlay_i,
   input  wire logic        soft_rst_req_i,
   input  wire logic [31:0] base_i,
   input  wire logic [31:0] addr_i,
   output logic            busy_o,
   output logic            trap_rdy_o,
   output logic            sysmgmt_ram_sel_o
);
   // ==========================================================
   // request shaper: one low clock then rearm gap
   logic [3:0] gap_r, gap_nxt, lead_r, lead_nxt;
   logic       int_n_r, int_n_nxt, fl_n_r, fl_n_nxt, srs_r, srs_nxt;
   logic       rdy_r, rdy_nxt, armed_r, armed_nxt, fire;

   always_comb begin
      fire      = (smi_req_i | trap_req_i) & (gap_r == 4'h0);
      int_n_nxt = ~fire;
      // flush goes with the request when memory is overlaid
      fl_n_nxt  = ~(fire & overlay_i);
      // hold inactive four clocks after each assertion
      gap_nxt   = fire ? `SMR_INT_REARM : (gap_r != 4'h0 ? gap_r - 4'h1 : 4'h0);
      // trap ready comes three clocks after the request
      lead_nxt  = (fire & trap_req_i) ? `SMR_TRAP_LEAD : (lead_r != 4'h0 ? lead_r - 4'h1 : 4'h0);
      rdy_nxt   = (lead_r == 4'h1);
      // soft reset only once the hard power-up reset has been seen
      armed_nxt = 1'b1;
      srs_nxt   = soft_rst_req_i & armed_r;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         gap_r   <= 4'h0;
         lead_r  <= 4'h0;
         int_n_r <= 1'b1;
         fl_n_r  <= 1'b1;
         rdy_r   <= 1'b0;
         armed_r <= 1'b0;
         srs_r   <= 1'b0;
      end else begin
         gap_r   <= gap_nxt;
         lead_r  <= lead_nxt;
         int_n_r <= int_n_nxt;
         fl_n_r  <= fl_n_nxt;
         rdy_r   <= rdy_nxt;
         armed_r <= armed_nxt;
         srs_r   <= srs_nxt;
      end
   end

   // ==========================================================
   // pins and decode; memory steered only while active is low
   assign link.sysmgmt_int_n = int_n_r;
   assign link.flush_n       = fl_n_r;
   assign link.soft_reset_in = srs_r;
   assign busy_o             = (gap_r != 4'h0);
   assign trap_rdy_o         = rdy_r;
   assign sysmgmt_ram_sel_o        = ~link.sysmgmt_active_n & (addr_i >= base_i)
                               & (addr_i - base_i < `SMR_RAM_SPAN);
endmodule

/* File: sim/smr_link_assertions.sv */
// Purpose: pin-level checks between the two management link ends
// Assumes: single clock, srst_i synchronous active high
// Notes:   core-side causes are not visible here; the bench judges them
`timescale 1ns/1ps
module smr_link_assertions (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic sysmgmt_int_n,
   input wire logic soft_reset_in,
   input wire logic flush_n,
   input wire logic sysmgmt_active_n,
   input wire logic addr_strobe_n
);
   // ==========================================================
   // link timing
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);

   a_reset_idle: assert property ($fell(srst_i) |->
      sysmgmt_active_n && addr_strobe_n && sysmgmt_int_n && flush_n && !soft_reset_in)
      else $error("link not idle after reset");
   a_rearm_gap: assert property ($fell(sysmgmt_int_n) |=> sysmgmt_int_n [*4])
      else $error("request line not held high for rearm");
   a_flush_with_req: assert property (!flush_n |-> !sysmgmt_int_n)
      else $error("flush without request");
   a_strobe_pulse: assert property (!addr_strobe_n |=> addr_strobe_n)
      else $error("strobe longer than one clock");
   a_save_gap: assert property ($fell(sysmgmt_active_n) |->
      not (##[0:19] !addr_strobe_n))
      else $error("save strobe too soon after active");
   a_save_strobe: assert property ($fell(sysmgmt_active_n) |->
      ##[20:24] !addr_strobe_n)
      else $error("no save strobe after active");
   a_exit_gap: assert property ($rose(sysmgmt_active_n) |->
      not (##[0:19] !addr_strobe_n))
      else $error("exit strobe too soon after release");
   a_exit_strobe: assert property ($rose(sysmgmt_active_n) |->
      ##[20:24] !addr_strobe_n)
      else $error("no strobe after active release");
   a_active_held: assert property ($fell(sysmgmt_active_n) |=>
      !sysmgmt_active_n [*8])
      else $error("active dropped during save");
   a_soft_idle: assert property (soft_reset_in |-> ##[1:6] sysmgmt_active_n)
      else $error("active not idle after soft reset");
endmodule

/* File: sim/tb_sysmgmt_interrupt_and_soft_reset.sv */
// Purpose: both link ends joined, user sides driven and judged
// Assumes: 40 MHz clock, synchronous active-high reset
// Notes:   latency windows allow a few clocks of sampling offset
`timescale 1ns/1ps
`include "smr_defs.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
   $display("Error %s expected %0h seen %0h", n, e, a); end end
module tb_sysmgmt_interrupt_and_soft_reset;
   // ==========================================================
   // stimulus and observed signals
   logic        clk_sys_i = 1'b0, srst_i = 1'b1;
   logic        boundary = 1'b1, locked = 1'b0, nmi_req = 1'b0, wbuf_empty = 1'b1;
   logic        resume = 1'b0, restart_req = 1'b0, base_wr = 1'b0, cr0_wr = 1'b0;
   logic        cd = 1'b1, nw = 1'b1, smi_req = 1'b0, trap_req = 1'b0;
   logic        overlay = 1'b0, soft_req = 1'b0;
   logic [31:0] base_wd = 32'h0, addr = 32'h0, fetch_addr, save_top, base;
   logic [31:0] exp_base = 32'h0005_0000;
   logic        smi_taken, nmi_taken, in_smm, fetch_go, cd_q, nw_q, snoop;
   logic        restart_ok, resume_done, trap_rdy, sysmgmt_ram_sel;
   logic        flush, core_rst, busy;
   smr_pkg::smr_opclass_type rclass = smr_pkg::OP_IO;
   int          failures = 0, comparisons = 0;

   always #12.5 clk_sys_i = ~clk_sys_i;

   // ==========================================================
   // the two ends and the pin checker
   smr_link_if i_smr_link_if (.clk_sys_i(clk_sys_i));
   wire act_n = i_smr_link_if.sysmgmt_active_n;
   smr_cpu_end i_smr_cpu_end (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(i_smr_link_if),
      .boundary_i(boundary), .locked_i(locked), .nmi_req_i(nmi_req),
      .wbuf_empty_i(wbuf_empty), .resume_instr_i(resume), .restart_req_i(restart_req),
      .restart_class_i(rclass), .base_wr_i(base_wr), .base_wdata_i(base_wd),
      .cr0_wr_i(cr0_wr), .cd_i(cd), .nw_i(nw), .smi_taken_o(smi_taken),
      .nmi_taken_o(nmi_taken), .in_smm_o(in_smm), .fetch_go_o(fetch_go),
      .fetch_addr_o(fetch_addr), .save_top_o(save_top), .base_o(base), .cd_o(cd_q),
      .nw_o(nw_q), .snoop_en_o(snoop), .restart_ok_o(restart_ok),
      .resume_done_o(resume_done), .core_reset_o(core_rst), .flush_o(flush));
   smr_sys_end i_smr_sys_end (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(i_smr_link_if),
      .smi_req_i(smi_req), .trap_req_i(trap_req), .overlay_i(overlay),
      .soft_rst_req_i(soft_req), .base_i(base), .addr_i(addr), .busy_o(busy),
      .trap_rdy_o(trap_rdy), .sysmgmt_ram_sel_o(sysmgmt_ram_sel));
   smr_link_assertions i_smr_link_assertions (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .sysmgmt_int_n(i_smr_link_if.sysmgmt_int_n),
      .soft_reset_in(i_smr_link_if.soft_reset_in), .flush_n(i_smr_link_if.flush_n),
      .sysmgmt_active_n(act_n), .addr_strobe_n(i_smr_link_if.addr_strobe_n));

   // ==========================================================
   // shared tasks
   task automatic print_verdict;
      if (failures == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // counts clocks until the chosen event; a hang ends the run
   task automatic wait_for(input int sel, output int n);
      logic hit;
      hit = 1'b0;
      n = 0;
      while (!hit && n < 2000) begin
         @(negedge clk_sys_i);
         n++;
         case (sel)
            0: hit = (act_n === 1'b0);
            1: hit = (act_n === 1'b1);
            2: hit = (fetch_go === 1'b1);
            3: hit = (smi_taken === 1'b1);
            4: hit = (resume_done === 1'b1);
            5: hit = (trap_rdy === 1'b1);
            default: hit = (i_smr_link_if.sysmgmt_int_n === 1'b0);
         endcase
      end
      if (!hit) begin
         failures++;
         print_verdict();
      end
   endtask

   // one-clock request; the next call starts a clock later, never at the same edge
   task automatic pulse(input int sel);
      @(posedge clk_sys_i);
      case (sel)
         0: smi_req <= 1'b1;
         1: trap_req <= 1'b1;
         2: resume <= 1'b1;
         default: soft_req <= 1'b1;
      endcase
      @(posedge clk_sys_i);
      {smi_req, trap_req, resume, soft_req} <= 4'h0;
   endtask

   task automatic leave;
      int n, t;
      pulse(2);
      wait_for(1, n);
      `CHK("restore_clks", 1'b1, n >= 238 && n <= 242)
      wait_for(4, t);
      `CHK("exit_clks", 1'b1, n + t >= 258 && n + t <= 264)
   endtask

   // ==========================================================
   // scenarios
   task automatic check_reset;
      @(negedge clk_sys_i);
      `CHK("base", `SMR_BASE_RST, base)
      `CHK("fetch_addr", `SMR_RESET_VEC, fetch_addr)
      `CHK("save_top", `SMR_BASE_RST + `SMR_SAVE_TOP_OFS, save_top)
      `CHK("cache_bits", 2'b11, {cd_q, nw_q})
      `CHK("active_n", 1'b1, act_n)
   endtask

   // entry held off by boundary, lock and full write buffer, with overlay flush
   task automatic entry_gated;
      int n, t;
      @(posedge clk_sys_i);
      base_wr <= 1'b1;
      base_wd <= exp_base;
      cr0_wr <= 1'b1;
      {cd, nw} <= 2'b00;
      {boundary, locked, wbuf_empty, nmi_req, overlay} <= 5'b01011;
      @(posedge clk_sys_i);
      {base_wr, cr0_wr} <= 2'b00;
      pulse(0);
      repeat (5) @(negedge clk_sys_i);
      `CHK("flush", 1'b1, flush)
      repeat (3) @(negedge clk_sys_i);
      `CHK("nmi_blocked", 1'b0, nmi_taken)
      `CHK("off_boundary", 1'b0, in_smm)
      @(posedge clk_sys_i);
      boundary <= 1'b1;
      repeat (4) @(negedge clk_sys_i);
      `CHK("off_lock", 1'b0, in_smm)
      @(posedge clk_sys_i);
      locked <= 1'b0;
      wait_for(3, n);
      `CHK("nmi_behind", 1'b0, nmi_taken)
      repeat (6) @(negedge clk_sys_i);
      `CHK("off_writes", 1'b1, act_n)
      @(posedge clk_sys_i);
      wbuf_empty <= 1'b1;
      wait_for(0, n);
      wait_for(2, t);
      `CHK("save_window", 1'b1, t >= 159 && t <= 162)
      `CHK("handler_addr", exp_base + `SMR_HANDLER_OFS, fetch_addr)
      @(posedge clk_sys_i);
      addr <= exp_base + 32'h0000_0100;
      @(negedge clk_sys_i);
      `CHK("decode_in", 1'b1, sysmgmt_ram_sel)
      @(posedge clk_sys_i);
      addr <= exp_base + `SMR_RAM_SPAN;
      @(negedge clk_sys_i);
      `CHK("decode_out", 1'b0, sysmgmt_ram_sel)
      @(posedge clk_sys_i);
      addr <= exp_base;
      leave();
      `CHK("decode_idle", 1'b0, sysmgmt_ram_sel)
      `CHK("nmi_free", 1'b1, nmi_taken)
      @(posedge clk_sys_i);
      {nmi_req, overlay} <= 2'b00;
   endtask

   // requests during a handler: one refused by the gap, one kept, one dropped
   task automatic back_to_back;
      int n, t;
      pulse(0);
      wait_for(3, n);
      wait_for(2, t);
      `CHK("entry_clks", 1'b1, t >= 161 && t <= 165)
      pulse(0);
      @(negedge clk_sys_i);
      `CHK("busy", 1'b1, busy)
      pulse(0);
      repeat (6) @(posedge clk_sys_i);
      pulse(0);
      leave();
      `CHK("pending_take", 1'b1, smi_taken)
      wait_for(0, n);
      `CHK("pending_soon", 1'b1, n <= 8)
      wait_for(2, t);
      leave();
      repeat (300) @(negedge clk_sys_i);
      `CHK("one_pending", 1'b0, in_smm)
   endtask

   task automatic trap_lead;
      int n, t;
      pulse(1);
      wait_for(6, n);
      wait_for(5, t);
      `CHK("trap_lead", 1'b1, t >= 3 && t <= 4)
      wait_for(2, t);
      leave();
   endtask

   // soft reset after a handler: vector restored, base and cache bits kept
   task automatic soft_reset_keep;
      int n;
      pulse(3);
      wait_for(2, n);
      `CHK("soft_vector", `SMR_RESET_VEC, fetch_addr)
      `CHK("core_reset", 1'b1, core_rst)
      `CHK("base_kept", exp_base, base)
      `CHK("save_top", exp_base + `SMR_SAVE_TOP_OFS, save_top)
      `CHK("cache_kept", 2'b00, {cd_q, nw_q})
      `CHK("snoop", 1'b1, snoop)
   endtask

   task automatic restart_classes;
      for (int c = 0; c < 3; c++) begin
         @(posedge clk_sys_i);
         restart_req <= 1'b1;
         rclass <= smr_pkg::smr_opclass_type'(c);
         @(negedge clk_sys_i);
         `CHK("restart_ok", (c != 2), restart_ok)
      end
      @(posedge clk_sys_i);
      restart_req <= 1'b0;
   endtask

   // main sequence: four clocks of reset, then each scenario in turn
   initial begin
      repeat (4) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      check_reset();
      entry_gated();
      back_to_back();
      trap_lead();
      soft_reset_keep();
      restart_classes();
      print_verdict();
   end
endmodule
